/* hw/oap_defines.svh */
// Register map, field layout and constants of the optical acquisition controller
`ifndef OAP_DEFINES_SVH
`define OAP_DEFINES_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OAP_A_CTRL 8'h00
`define OAP_A_RATE 8'h04
`define OAP_A_PW 8'h08
`define OAP_A_AMP0 8'h0c
`define OAP_A_SEARCH 8'h1c
`define OAP_A_THRESH 8'h20
`define OAP_A_XTALK 8'h24
`define OAP_A_STAT 8'h28
`define OAP_A_EN 8'h2c
`define OAP_A_CLR 8'h30
`define OAP_A_WRP 8'h34
`define OAP_A_OVF 8'h38
`define OAP_A_RDP 8'h3c
`define OAP_A_DATA 8'h40
`define OAP_A_STATE 8'h44
`define OAP_A_STEP 8'h04

// ------------------------------------------------------------
// Field positions and widths
// ------------------------------------------------------------
`define OAP_IRQ_PROX 0
`define OAP_IRQ_AMB 1
`define OAP_IRQ_W 2
`define OAP_LEDS 4
`define OAP_ADC_W 19
`define OAP_PTR_W 5
`define OAP_FIFO_DEPTH 32
`define OAP_THR_SHIFT 11

// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define OAP_RATE_MAX 3'h6
`define OAP_OVF_MAX 5'h1f
`define OAP_RST_RATE 3'h0
`define OAP_RST_PW 2'h0
`define OAP_RATE_MIN_SPS 50
`define OAP_RATE_MAX_SPS 3200
`define OAP_LED_FULL_MA 150
`define OAP_PW_MIN_US 70
`define OAP_PW_MAX_US 420

// ------------------------------------------------------------
// LED masks per stage and mode
// ------------------------------------------------------------
`define OAP_MASK_SEARCH 4'h1
`define OAP_MASK_MODE0 4'h1
`define OAP_MASK_MODE1 4'h3
`define OAP_MASK_MODE2 4'h7
`define OAP_MASK_MODE3 4'hf

`endif

/* hw/oap_pkg.sv */
// Types shared by the optical acquisition controller
package oap_pkg;

  typedef enum logic [1:0] {
    OAP_ST_IDLE = 2'b00,
    OAP_ST_PROX = 2'b01,
    OAP_ST_ACQ = 2'b10
  } oap_state_t;

  typedef struct packed {
    logic ambient_detect_mode;
    logic [1:0] mode;
    logic start;
  } oap_ctrl_t;

  typedef struct packed {
    logic [3:0] led_mask;
    logic [31:0] led_amplitude;
    logic [2:0] rate;
    logic [1:0] pulse_width;
    logic ambient_cancel;
    logic [19:0] crosstalk_cancel_code;
  } oap_drive_t;

endpackage : oap_pkg

/* hw/oap_ctrl.sv */
// Optical acquisition and proximity controller with Avalon-MM register slave
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
//
// Functional notes
// - Converted samples are kept in a 32-entry first-in first-out store.
// - Each stored converter result is 19 bits wide.
// - Software selects output sample rate from 50 to 3200 samples per second.
// - Ambient saturation sets a flag; interrupt only while its enable is set.
// - Ambient cancellation on after reset; detect mode bit bypasses it.
// - LED current programmable from zero to 150 mA via amplitude codes.
// - LED pulse width programmable between 70 and 420 microseconds.
// - Proximity search stage runs only while proximity enable is one.
// - Search stage pulses LED1 alone at the search amplitude.
// - Count above threshold: raise flag, flush store, enter programmed mode.
// - Count below threshold in acquisition: back to search, no flag.
// - Threshold is the programmed threshold value times 2048.
// - With proximity disabled, start goes straight to programmed acquisition.
// - Interrupt pin is active low, open drain, sources chosen by enables.
// - Per-channel crosstalk codes subtract pulse-coherent DC before conversion.
`include "oap_defines.svh"

module oap_ctrl
  import oap_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic fe_adc_clk_i,
  input wire logic [18:0] fe_adc_data_i,
  input wire logic fe_amb_ovf_i,
  output oap_drive_t fe_drive_o,
  output logic irq_out_n_o,
  output logic irq_out_n_oe_o
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [2:0] clk_sync;
  logic [2:0] ovf_sync;
  logic [18:0] adc_pipe [3];
  logic clk_lvl, next_clk_lvl, ovf_lvl, next_ovf_lvl;
  logic adc_edge, amb_edge;

  logic accept, done;
  logic [31:0] bemask, next_readdata;
  logic next_wait;

  oap_ctrl_t ctrl, next_ctrl;
  logic [2:0] rate, next_rate;
  logic [1:0] pw, next_pw;
  logic [7:0] amp [4];
  logic [7:0] next_amp [4];
  logic [7:0] search_amp, next_search_amp;
  logic [7:0] thresh, next_thresh;
  logic [19:0] xtalk, next_xtalk;
  logic [1:0] irq_en, next_irq_en;
  logic [1:0] irq_stat, next_irq_stat;
  logic [1:0] stat_set, stat_clr;
  logic next_irq_oe;

  oap_state_t state, next_state;
  logic flush, push, pop, prox_hit;
  logic [18:0] fifo_mem [`OAP_FIFO_DEPTH];
  logic [5:0] wr6, next_wr6, rd6, next_rd6, count;
  logic [4:0] ovf, next_ovf;
  logic [18:0] sample, thr_full;
  oap_drive_t next_drive;

  // ------------------------------------------------------------
  // Link sampling
  // ------------------------------------------------------------
  // The converter holds data well past its clock edge; the data pipe is
  // aligned with the clock synchroniser so the edge picks matching data.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_sync <= 3'h0;
      ovf_sync <= 3'h0;
      clk_lvl <= 1'b0;
      ovf_lvl <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        adc_pipe[i] <= 19'h0;
      end
    end else begin
      clk_sync <= {clk_sync[1:0], fe_adc_clk_i};
      ovf_sync <= {ovf_sync[1:0], fe_amb_ovf_i};
      clk_lvl <= next_clk_lvl;
      ovf_lvl <= next_ovf_lvl;
      adc_pipe[0] <= fe_adc_data_i;
      adc_pipe[1] <= adc_pipe[0];
      adc_pipe[2] <= adc_pipe[1];
    end
  end

  always_comb begin
    next_clk_lvl = clk_lvl;
    next_ovf_lvl = ovf_lvl;
    if (clk_sync[1] == clk_sync[2]) begin
      next_clk_lvl = clk_sync[2];
    end
    if (ovf_sync[1] == ovf_sync[2]) begin
      next_ovf_lvl = ovf_sync[2];
    end
    adc_edge = next_clk_lvl & ~clk_lvl;
    amb_edge = next_ovf_lvl & ~ovf_lvl;
    sample = adc_pipe[2];
    thr_full = {thresh, `OAP_THR_SHIFT'(0)};
  end

  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  // One wait cycle per access: data is looked up at the accept edge and side
  // effects happen at the completion edge, where the master sees it.
  always_comb begin
    accept = (avs_read_i | avs_write_i) & avs_waitrequest_o;
    done = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
    next_wait = ~accept;
    bemask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
              {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    count = wr6 - rd6;
    next_readdata = avs_readdata_o;
    if (accept) begin
      next_readdata = 32'h0;
      case (avs_address_i)
        `OAP_A_CTRL: next_readdata = {28'h0, ctrl};
        `OAP_A_RATE: next_readdata = {29'h0, rate};
        `OAP_A_PW: next_readdata = {30'h0, pw};
        `OAP_A_SEARCH: next_readdata = {24'h0, search_amp};
        `OAP_A_THRESH: next_readdata = {24'h0, thresh};
        `OAP_A_XTALK: next_readdata = {12'h0, xtalk};
        `OAP_A_STAT: next_readdata = {30'h0, irq_stat};
        `OAP_A_EN: next_readdata = {30'h0, irq_en};
        `OAP_A_WRP: next_readdata = {27'h0, wr6[4:0]};
        `OAP_A_OVF: next_readdata = {27'h0, ovf};
        `OAP_A_RDP: next_readdata = {27'h0, rd6[4:0]};
        `OAP_A_DATA: begin
          if (count != 6'h0) begin
            next_readdata = {13'h0, fifo_mem[rd6[4:0]]};
          end
        end
        `OAP_A_STATE: next_readdata = {24'h0, count, state};
        default: begin
          for (int i = 0; i < `OAP_LEDS; i++) begin
            if (avs_address_i == 8'(`OAP_A_AMP0 + i * `OAP_A_STEP)) begin
              next_readdata = {24'h0, amp[i]};
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    wv = avs_writedata_i & bemask;
    next_ctrl = ctrl;
    next_rate = rate;
    next_pw = pw;
    next_amp = amp;
    next_search_amp = search_amp;
    next_thresh = thresh;
    next_xtalk = xtalk;
    next_irq_en = irq_en;
    stat_clr = 2'h0;
    if (done && avs_write_i) begin
      case (avs_address_i)
        `OAP_A_CTRL: begin
          if (avs_byteenable_i[0]) begin
            next_ctrl = oap_ctrl_t'(wv[3:0]);
          end
        end
        `OAP_A_RATE: begin
          if (avs_byteenable_i[0]) begin
            // Codes past 3200 sps clamp to the top rate
            next_rate = (wv[7:0] > 8'(`OAP_RATE_MAX)) ? `OAP_RATE_MAX : wv[2:0];
          end
        end
        `OAP_A_PW: begin
          if (avs_byteenable_i[0]) begin
            next_pw = wv[1:0];
          end
        end
        `OAP_A_SEARCH: begin
          if (avs_byteenable_i[0]) begin
            next_search_amp = wv[7:0];
          end
        end
        `OAP_A_THRESH: begin
          if (avs_byteenable_i[0]) begin
            next_thresh = wv[7:0];
          end
        end
        `OAP_A_XTALK: begin
          next_xtalk = (xtalk & ~bemask[19:0]) | wv[19:0];
        end
        `OAP_A_EN: begin
          if (avs_byteenable_i[0]) begin
            next_irq_en = wv[1:0];
          end
        end
        `OAP_A_CLR: stat_clr = wv[1:0];
        default: begin
          for (int i = 0; i < `OAP_LEDS; i++) begin
            if (avs_address_i == 8'(`OAP_A_AMP0 + i * `OAP_A_STEP) && avs_byteenable_i[0]) begin
              next_amp[i] = wv[7:0];
            end
          end
        end
      endcase
    end
    // Only the bits shown to the host are cleared by the read
    if (done && avs_read_i && avs_address_i == `OAP_A_STAT) begin
      stat_clr = avs_readdata_o[1:0];
    end
  end

  // ------------------------------------------------------------
  // Stage sequencing and sample store
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    flush = 1'b0;
    push = 1'b0;
    prox_hit = 1'b0;
    case (state)
      OAP_ST_IDLE: begin
        if (ctrl.start) begin
          next_state = irq_en[`OAP_IRQ_PROX] ? OAP_ST_PROX : OAP_ST_ACQ;
        end
      end
      OAP_ST_PROX: begin
        if (!ctrl.start) begin
          next_state = OAP_ST_IDLE;
        end else if (!irq_en[`OAP_IRQ_PROX]) begin
          next_state = OAP_ST_ACQ;
        end else if (adc_edge && sample > thr_full) begin
          prox_hit = 1'b1;
          flush = 1'b1;
          next_state = OAP_ST_ACQ;
        end
      end
      OAP_ST_ACQ: begin
        if (!ctrl.start) begin
          next_state = OAP_ST_IDLE;
        end else if (adc_edge) begin
          if (irq_en[`OAP_IRQ_PROX] && sample < thr_full) begin
            next_state = OAP_ST_PROX;
          end else begin
            push = 1'b1;
          end
        end
      end
      default: next_state = OAP_ST_IDLE;
    endcase

    pop = done && avs_read_i && avs_address_i == `OAP_A_DATA && count != 6'h0;
    next_wr6 = wr6;
    next_rd6 = rd6;
    next_ovf = ovf;
    if (pop) begin
      next_rd6 = rd6 + 6'h1;
      next_ovf = 5'h0;
    end
    if (done && avs_write_i && avs_address_i == `OAP_A_RDP && avs_byteenable_i[0]) begin
      // Moving the read pointer back lets old entries be read again
      next_rd6 = wr6 - {1'b0, wr6[4:0] - avs_writedata_i[4:0]};
    end
    if (push) begin
      if (count == 6'(`OAP_FIFO_DEPTH) && !pop) begin
        // Full store drops the new sample and counts the loss
        next_ovf = (ovf == `OAP_OVF_MAX) ? ovf : ovf + 5'h1;
      end else begin
        next_wr6 = wr6 + 6'h1;
      end
    end
    if (flush) begin
      next_wr6 = 6'h0;
      next_rd6 = 6'h0;
      next_ovf = 5'h0;
    end
  end

  // ------------------------------------------------------------
  // Front-end drive and interrupt
  // ------------------------------------------------------------
  always_comb begin
    next_drive.led_mask = 4'h0;
    next_drive.led_amplitude = {amp[3], amp[2], amp[1], amp[0]};
    if (next_state == OAP_ST_PROX) begin
      next_drive.led_mask = `OAP_MASK_SEARCH;
      next_drive.led_amplitude = {24'h0, search_amp};
    end else if (next_state == OAP_ST_ACQ) begin
      case (ctrl.mode)
        2'h0: next_drive.led_mask = `OAP_MASK_MODE0;
        2'h1: next_drive.led_mask = `OAP_MASK_MODE1;
        2'h2: next_drive.led_mask = `OAP_MASK_MODE2;
        default: next_drive.led_mask = `OAP_MASK_MODE3;
      endcase
    end
    next_drive.rate = rate;
    next_drive.pulse_width = pw;
    next_drive.ambient_cancel = ~ctrl.ambient_detect_mode;
    next_drive.crosstalk_cancel_code = xtalk;

    stat_set = 2'h0;
    stat_set[`OAP_IRQ_PROX] = prox_hit;
    stat_set[`OAP_IRQ_AMB] = amb_edge;
    // A new event in the clearing cycle survives
    next_irq_stat = (irq_stat & ~stat_clr) | stat_set;
    next_irq_oe = |(next_irq_stat & next_irq_en);
  end

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0;
      ctrl <= '0;
      rate <= `OAP_RST_RATE;
      pw <= `OAP_RST_PW;
      search_amp <= 8'h0;
      thresh <= 8'h0;
      xtalk <= 20'h0;
      irq_en <= 2'h0;
      irq_stat <= 2'h0;
      state <= OAP_ST_IDLE;
      wr6 <= 6'h0;
      rd6 <= 6'h0;
      ovf <= 5'h0;
      fe_drive_o <= '0;
      irq_out_n_o <= 1'b0;
      irq_out_n_oe_o <= 1'b0;
      for (int i = 0; i < `OAP_LEDS; i++) begin
        amp[i] <= 8'h0;
      end
    end else begin
      avs_waitrequest_o <= next_wait;
      avs_readdata_o <= next_readdata;
      ctrl <= next_ctrl;
      rate <= next_rate;
      pw <= next_pw;
      search_amp <= next_search_amp;
      thresh <= next_thresh;
      xtalk <= next_xtalk;
      irq_en <= next_irq_en;
      irq_stat <= next_irq_stat;
      state <= next_state;
      wr6 <= next_wr6;
      rd6 <= next_rd6;
      ovf <= next_ovf;
      fe_drive_o <= next_drive;
      irq_out_n_o <= 1'b0;
      irq_out_n_oe_o <= next_irq_oe;
      amp <= next_amp;
    end
  end

  // Storage array has no reset; it is only read below the write pointer
  always_ff @(posedge clk_sys_i) begin
    if (push && next_wr6 != wr6) begin
      fifo_mem[wr6[4:0]] <= sample;
    end
  end

endmodule : oap_ctrl

/* bench/oap_ctrl_assertions.sv */
// Port-level assertions for the optical acquisition controller
`timescale 1ns/1ns
`include "oap_defines.svh"
module oap_ctrl_assertions
  import oap_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic fe_adc_clk_i,
  input wire logic [18:0] fe_adc_data_i,
  input wire logic fe_amb_ovf_i,
  input wire oap_drive_t fe_drive_o,
  input wire logic irq_out_n_o,
  input wire logic irq_out_n_oe_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // ------------------------------------------------------------
  // Ages since a status, enable or clear register access and since any bus access or front-end event
  // ------------------------------------------------------------
  logic acc;
  logic [3:0] clr_age;
  logic [3:0] next_clr_age;
  logic [3:0] ev_age;
  logic [3:0] next_ev_age;
  assign acc = (avs_read_i || avs_write_i) && avs_waitrequest_o;
  always_comb begin
    next_clr_age = (clr_age == 4'hf) ? clr_age : clr_age + 4'h1;
    next_ev_age = (ev_age == 4'hf) ? ev_age : ev_age + 4'h1;
    if (acc && avs_address_i inside {`OAP_A_STAT, `OAP_A_EN, `OAP_A_CLR}) begin
      next_clr_age = 4'h0;
    end
    // Levels, not edges: the link inputs are asynchronous to this clock
    if (acc || fe_adc_clk_i || fe_amb_ovf_i) begin
      next_ev_age = 4'h0;
    end
  end
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clr_age <= 4'hf;
      ev_age <= 4'hf;
    end else begin
      clr_age <= next_clr_age;
      ev_age <= next_ev_age;
    end
  end
  sequence s_accept;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_ctrl_wr;
    s_accept ##0 (avs_write_i && avs_address_i == `OAP_A_CTRL && avs_byteenable_i[0]);
  endsequence
  a_irq_pin_low: assert property (irq_out_n_o == 1'b0)
    else $error("interrupt pin value not low");
  a_irq_cause: assert property ($rose(irq_out_n_oe_o) |-> ev_age <= 4'ha)
    else $error("interrupt raised without a cause");
  a_irq_sticky: assert property ($fell(irq_out_n_oe_o) |-> clr_age <= 4'h4)
    else $error("interrupt dropped without status access");
  a_cancel_follow: assert property (s_ctrl_wr |-> ##[2:3]
    fe_drive_o.ambient_cancel == !$past(avs_writedata_i[3], 2))
    else $error("ambient cancel does not follow detect mode");
  a_rate_range: assert property (fe_drive_o.rate <= `OAP_RATE_MAX)
    else $error("rate code above top");
  a_mask_legal: assert property (fe_drive_o.led_mask inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
    else $error("illegal led mask");
  a_wait_answer: assert property (s_accept |=> !avs_waitrequest_o)
    else $error("no answer one cycle after accept");
  a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  a_wait_idle: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("waitrequest low without request");
  a_rdata_hold: assert property ($changed(avs_readdata_o) |->
    $past(avs_waitrequest_o && (avs_read_i || avs_write_i)))
    else $error("read data changed without accept");
endmodule : oap_ctrl_assertions

bind oap_ctrl oap_ctrl_assertions oap_ctrl_assertions_inst (.clk_sys_i, .arst_n_i,
  .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
  .avs_readdata_o, .avs_waitrequest_o, .fe_adc_clk_i, .fe_adc_data_i, .fe_amb_ovf_i,
  .fe_drive_o, .irq_out_n_o, .irq_out_n_oe_o);

/* bench/oap_fe_model.sv */
// Converter front-end stand-in: sample frames and ambient saturation
`timescale 1ns/1ns
module oap_fe_model (
  output logic fe_adc_clk_o,
  output logic [18:0] fe_adc_data_o,
  output logic fe_amb_ovf_o
);
  initial begin
    fe_adc_clk_o = 1'b0;
    fe_adc_data_o = 19'h0;
    fe_amb_ovf_o = 1'b0;
  end
  // ------------------------------------------------------------
  // One 400 ns frame per sample; link clock rests low between frames
  // ------------------------------------------------------------
  // Changes land 10 ns after a system clock edge, except those at the 400 ns frame end, which land on one
  task automatic send(input logic [18:0] v, input int gap);
    #10 fe_adc_data_o = v;
    #50 fe_adc_clk_o = 1'b1;
    #200 fe_adc_clk_o = 1'b0;
    #140;
    // Idle data shows the inverse, so a late sample is caught
    if (gap > 0) fe_adc_data_o = ~v;
    #(gap);
  endtask : send
  task automatic saturate();
    #10 fe_amb_ovf_o = 1'b1;
    #390 fe_amb_ovf_o = 1'b0;
  endtask : saturate
endmodule : oap_fe_model

/* bench/testbench.sv */
// Self-checking bench for the optical acquisition controller
`timescale 1ns/1ns
`include "oap_defines.svh"
module testbench;
  import oap_pkg::*;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic fe_adc_clk_i;
  logic [18:0] fe_adc_data_i;
  logic fe_amb_ovf_i;
  oap_drive_t fe_drive_o;
  logic irq_out_n_o;
  logic irq_out_n_oe_o;
  int mismatches = 0;
  int num_checks = 0;
  logic [31:0] rd;
  logic [31:0] amp;
  logic [18:0] first;
  logic [7:0] t;
  logic [7:0] sa;
  always #25 clk_sys_i = ~clk_sys_i;
  oap_ctrl oap_ctrl_inst (.clk_sys_i, .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .fe_adc_clk_i,
    .fe_adc_data_i, .fe_amb_ovf_i, .fe_drive_o, .irq_out_n_o, .irq_out_n_oe_o);
  oap_fe_model oap_fe_model_inst (.fe_adc_clk_o(fe_adc_clk_i), .fe_adc_data_o(fe_adc_data_i),
    .fe_amb_ovf_o(fe_amb_ovf_i));
  // ------------------------------------------------------------
  // Expectations, bus cycles and comparisons
  // ------------------------------------------------------------
  function automatic logic [18:0] thr(input logic [7:0] v);
    return {v, 11'h0};
  endfunction : thr
  function automatic logic [3:0] lmask(input int m);
    return (4'h1 << (m + 1)) - 4'h1;
  endfunction : lmask
  task automatic results();
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    num_checks++;
    if (got !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, e);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o;
    if (avs_waitrequest_o !== 1'b0) begin
      mismatches++;
      results();
    end
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rdchk
  task automatic smp(input logic [18:0] v);
    oap_fe_model_inst.send(v, int'($urandom_range(0, 1)) * 400);
  endtask : smp
  initial begin
    #2000000;
    mismatches++;
    results();
  end
  initial begin
    amp = $urandom(53111);
    repeat (20) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk(fe_drive_o.ambient_cancel, 1'b1);
    chk(irq_out_n_oe_o, 1'b0);
    chk(irq_out_n_o, 1'b0);
    rdchk(8'hfc, 32'h0);
    bus(1'b1, 8'hfc, 32'hffff);
    for (int r = 0; r < 8; r++) begin
      bus(1'b1, `OAP_A_RATE, r);
      rdchk(`OAP_A_RATE, (r > 6) ? 6 : r);
      chk(fe_drive_o.rate, (r > 6) ? 6 : r);
    end
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, `OAP_A_PW, p);
      rdchk(`OAP_A_PW, p);
      chk(fe_drive_o.pulse_width, p);
    end
    amp = $urandom;
    amp[31:24] = 8'hff;  // Top code, full current
    for (int i = 0; i < 4; i++) bus(1'b1, `OAP_A_AMP0 + 8'(4 * i), amp[8*i +: 8]);
    rdchk(`OAP_A_AMP0 + 8'h0c, 32'hff);
    chk(fe_drive_o.led_amplitude, amp);
    amp = $urandom & 32'hfffff;
    bus(1'b1, `OAP_A_XTALK, amp);
    rdchk(`OAP_A_XTALK, amp);
    chk(fe_drive_o.crosstalk_cancel_code, amp[19:0]);
    for (int i = 0; i < 4; i++) bus(1'b1, `OAP_A_AMP0 + 8'(4 * i), 32'h0);
    bus(1'b1, `OAP_A_CTRL, 32'h8);
    rdchk(`OAP_A_CTRL, 32'h8);
    chk(fe_drive_o.ambient_cancel, 1'b0);
    bus(1'b1, `OAP_A_CTRL, 32'h0);
    oap_fe_model_inst.saturate();
    chk(irq_out_n_oe_o, 1'b0);
    bus(1'b1, `OAP_A_EN, 32'h2);
    rdchk(`OAP_A_EN, 32'h2);
    chk(irq_out_n_oe_o, 1'b1);
    rdchk(`OAP_A_STAT, 32'h2);
    rdchk(`OAP_A_STAT, 32'h0);
    chk(irq_out_n_oe_o, 1'b0);
    oap_fe_model_inst.saturate();
    chk(irq_out_n_oe_o, 1'b1);
    bus(1'b1, `OAP_A_CLR, 32'h2);
    rdchk(`OAP_A_STAT, 32'h0);
    chk(irq_out_n_oe_o, 1'b0);
    bus(1'b1, `OAP_A_EN, 32'h0);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, `OAP_A_CTRL, 32'(2 * m + 1));
      rdchk(`OAP_A_STATE, 32'h2, 32'h3);
      chk(fe_drive_o.led_mask, lmask(m));
    end
    // Overfill by two: store keeps the oldest, count logs the losses
    for (int i = 0; i < 34; i++) begin
      amp = $urandom_range(1, 32'h7ffff);
      if (i == 0) first = amp[18:0];
      smp(amp[18:0]);
    end
    rdchk(`OAP_A_WRP, 32'h0);
    rdchk(`OAP_A_OVF, 32'h2);
    rdchk(`OAP_A_DATA, first);
    rdchk(`OAP_A_RDP, 32'h1);
    smp(19'h1);
    smp(19'h2);
    rdchk(`OAP_A_WRP, 32'h1);
    rdchk(`OAP_A_OVF, 32'h1);
    // Rewinding the read pointer to 0 leaves one entry: the sample 1 at slot 0
    bus(1'b1, `OAP_A_RDP, 32'h0);
    rdchk(`OAP_A_RDP, 32'h0);
    rdchk(`OAP_A_DATA, 32'h1);
    rdchk(`OAP_A_OVF, 32'h0);
    t = 8'($urandom_range(1, 254));
    sa = 8'($urandom);
    bus(1'b1, `OAP_A_THRESH, t);
    bus(1'b1, `OAP_A_SEARCH, sa);
    bus(1'b1, `OAP_A_EN, 32'h1);
    smp(thr(t) - 19'h1);
    rdchk(`OAP_A_STATE, 32'h1, 32'h3);
    chk(irq_out_n_oe_o, 1'b0);
    chk(fe_drive_o.led_mask, 4'h1);
    chk(fe_drive_o.led_amplitude, {24'h0, sa});
    smp(thr(t));
    rdchk(`OAP_A_STATE, 32'h1, 32'h3);
    smp(thr(t) + 19'h1);
    chk(irq_out_n_oe_o, 1'b1);
    rdchk(`OAP_A_STATE, 32'h2, 32'h3);
    chk(fe_drive_o.led_mask, 4'hf);
    rdchk(`OAP_A_WRP, 32'h0);
    rdchk(`OAP_A_RDP, 32'h0);
    rdchk(`OAP_A_OVF, 32'h0);
    smp(thr(t) + 19'h5);
    rdchk(`OAP_A_DATA, thr(t) + 19'h5);
    rdchk(`OAP_A_STAT, 32'h1);
    rdchk(`OAP_A_STAT, 32'h0);
    chk(irq_out_n_oe_o, 1'b0);
    results();
  end
endmodule : testbench
